// ==== tb_vepsp_port.sv ====
// Testbench: self-checking scenarios for the pixel/sync port
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_vepsp_port;
  logic clk_in = 1'b0, rst_in = 1'b1, master = 1'b0, wide = 1'b0, rsh = 1'b0, rsl = 1'b0;
  logic scr = 1'b1, bus_address_low_bit = 1'b0, ttx_en = 1'b0, hs_n = 1'b1, fv = 1'b0;
  logic [1:0] tmode = 2'b00;
  logic [15:0] pix;
  logic blank_n;
  vepsp_pkg::vepsp_timing_s tmg = {12'h002, 12'h005, 10'h001, 10'h002, 12'h040, 10'h010};
  vepsp_pkg::vepsp_pixel_s pixel_out, q[$];
  logic hsync_n_out, hsync_oe_out, fv_oe, sc_rst, ttx_req;
  logic fv_out, rtc_s, rtc_d, ttx_bit, ttx_bv;
  logic [6:0] addr_a, addr_b;
  logic lock, pal, dac_b, dac_d;
  int n_fail = 0, checks_done = 0, cyc = 0;
  // ---------------------------------------------
  // Clock, partner and design
  // ---------------------------------------------
  always #5 clk_in = ~clk_in;
  vepsp_src u_vepsp_src (.clk_in(clk_in), .pix_out(pix), .blank_n_out(blank_n));
  vepsp_port #(.PIXEL_W(16)) u_vepsp_port (.clk_in(clk_in), .rst_in(rst_in), .pixel_bus_in(pix),
    .blank_n_in(blank_n), .hsync_n_in(hs_n), .field_vsync_in(fv),
    .subcarrier_reset_or_realtime_pin_in(scr), .teletext_data_input_in(1'b1), // Idle high
    .bus_address_low_bit_in(bus_address_low_bit), .cfg_master_in(master), .cfg_tmode_in(tmode), .cfg_wide_in(wide),
    .pin_role_select_high_in(rsh), .pin_role_select_low_in(rsl), .cfg_teletext_en_in(ttx_en),
    .cfg_timing_in(tmg), .hsync_n_out(hsync_n_out), .hsync_oe_out(hsync_oe_out), .field_vsync_out(fv_out),
    .field_vsync_oe_out(fv_oe), .pixel_out(pixel_out), .subcarrier_reset_out(sc_rst),
    .realtime_sample_out(rtc_s), .realtime_data_out(rtc_d), .teletext_request_output_out(ttx_req),
    .teletext_bit_out(ttx_bit), .teletext_bit_valid_out(ttx_bv), .ctrl_addr_a_out(addr_a), .ctrl_addr_b_out(addr_b),
    .frame_locked_out(lock), .pal_out(pal), .dac_b_on_out(dac_b), .dac_d_on_out(dac_d));
  // Collect every emitted pixel; the hang guard ends a stuck run
  always @(posedge clk_in) begin
    if (pixel_out.valid === 1'b1) q.push_back(pixel_out);
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic reset(input logic w);
    wide = w;
    rst_in = 1'b1;
    tick(2);
    rst_in = 1'b0;
    `CHK({dac_b, dac_d, pal, lock, hsync_oe_out, hsync_n_out}, 6'h21)
    q.delete();
  endtask
  task automatic chk_last2(input logic [31:0] e);
    if (q.size() < 2) `CHK(q.size(), 2)
    else `CHK({q[$-1].cb, q[$-1].y, q[$].cr, q[$].y}, e)
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_pix8();
    logic [7:0] w[8] = '{8'hFF, 8'h00, 8'h00, 8'h80, 8'h10, 8'h20, 8'h30, 8'h40};
    reset(1'b0);
    foreach (w[i]) u_vepsp_src.put({8'hA5, w[i]}, 1, 1'b0);
    u_vepsp_src.release_bus();
    tick(6);
    chk_last2(32'h10203040);
    `CHK(lock, 1'b1)
    $display("test pix8 done");
  endtask
  task automatic t_blank();
    int n;
    n = q.size();
    repeat (4) u_vepsp_src.put(16'h1234, 1, 1'b1);
    u_vepsp_src.release_bus();
    tick(6);
    `CHK(q.size(), n)
    $display("test blank done");
  endtask
  task automatic t_pix16();
    reset(1'b1);
    u_vepsp_src.put(16'h5060, 2, 1'b0);
    u_vepsp_src.put(16'h7080, 2, 1'b0);
    u_vepsp_src.release_bus();
    tick(6);
    chk_last2(32'h50607080);
    $display("test pix16 done");
  endtask
  task automatic t_master();
    int k = 0, w = 0;
    master = 1'b1;
    for (int m = 1; m < 3; m++) begin
      tmode = m[1:0];
      tick(4);
      `CHK({hsync_oe_out, fv_oe}, 2'h3)
    end
    // Mode 2 vertical sync stays low for vs_width whole lines
    while (fv_out === 1'b0 && k < 2000) begin tick(1); k++; end
    while (fv_out !== 1'b0 && k < 2000) begin tick(1); k++; end
    while (fv_out === 1'b0 && w < 200) begin tick(1); w++; end
    `CHK(w, 128)
    k = 0;
    w = 0;
    // Skip a pulse already under way so only a whole one is measured
    while (hsync_n_out === 1'b0 && k < 200) begin tick(1); k++; end
    while (hsync_n_out !== 1'b0 && k < 200) begin tick(1); k++; end
    while (hsync_n_out === 1'b0 && w < 200) begin tick(1); w++; end
    `CHK(w, 5)
    master = 1'b0;
    tick(4);
    `CHK({hsync_oe_out, fv_oe}, 2'h0)
    $display("test master done");
  endtask
  task automatic t_pins();
    int p;
    hs_n = 1'b0;
    p = 0;
    repeat (6) begin tick(1); p += (lock === 1'b1); end
    `CHK(p, 1)
    hs_n = 1'b1;
    for (int r = 1; r < 3; r++) begin
      {rsh, rsl} = r[1:0];
      tick(4);
      scr = 1'b0;
      p = 0;
      repeat (6) begin tick(1); p += (sc_rst === 1'b1); end
      `CHK(p, (r == 1) ? 1 : 0)
      `CHK({rtc_s, rtc_d}, (r == 2) ? 2'b10 : 2'b00)
      scr = 1'b1;
    end
    for (int b = 0; b < 2; b++) begin
      bus_address_low_bit = b[0];
      tick(4);
      `CHK(addr_a[0], b[0])
      `CHK(addr_a !== addr_b, 1'b1)
      `CHK({ttx_req, ttx_bit, ttx_bv}, 3'b010)
      `CHK({rtc_s, rtc_d}, 2'b11)
    end
    $display("test pins done");
  endtask
  initial begin
    t_pix8();
    t_blank();
    t_master();
    t_pix16();
    t_pins();
    wrap_up();
  end
endmodule

// ==== vepsp_pkg.sv ====
// Package: constants, modes and carrier types for the video encoder pixel/sync port
package vepsp_pkg;

  // -----------------------------------------------------------------
  // Modes and encodings
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    VEPSP_TMODE0 = 2'b00,
    VEPSP_TMODE1 = 2'b01,
    VEPSP_TMODE2 = 2'b10,
    VEPSP_TMODE3 = 2'b11
  } vepsp_tmode_e;

  typedef enum logic [1:0] {
    VEPSP_PIN_OFF  = 2'b00,
    VEPSP_PIN_SCR  = 2'b01,
    VEPSP_PIN_RTC  = 2'b10,
    VEPSP_PIN_RSVD = 2'b11
  } vepsp_pinrole_e;

  typedef enum logic [1:0] {
    VEPSP_PH_CB = 2'b00,
    VEPSP_PH_Y0 = 2'b01,
    VEPSP_PH_CR = 2'b10,
    VEPSP_PH_Y1 = 2'b11
  } vepsp_phase_e;

  // -----------------------------------------------------------------
  // Reset defaults and constants
  // -----------------------------------------------------------------
  localparam logic       RST_MASTER      = 1'b0;   // Timing slave
  localparam logic [1:0] RST_TMODE       = 2'b00;  // Timing mode 0
  localparam logic       RST_WIDE        = 1'b0;   // 8-bit input
  localparam logic       RST_PAL         = 1'b0;   // NTSC
  localparam logic       RST_DAC_B_ON    = 1'b1;
  localparam logic       RST_DAC_D_ON    = 1'b0;
  localparam logic [6:0] CTRL_ADDR_BASE  = 7'h6A;  // Arbitrary base address
  localparam logic [7:0] TRC_FF          = 8'hFF;
  localparam logic [7:0] TRC_00          = 8'h00;
  localparam logic [11:0] DEF_LINE_LEN   = 12'h6B4;
  localparam logic [9:0]  DEF_FIELD_LINES = 10'h106;
  localparam logic [11:0] DEF_HS_START   = 12'h000;
  localparam logic [11:0] DEF_HS_WIDTH   = 12'h07E;
  localparam logic [9:0]  DEF_VS_START   = 10'h003;
  localparam logic [9:0]  DEF_VS_WIDTH   = 10'h003;

  // -----------------------------------------------------------------
  // Carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cb;
    logic [7:0] y;
    logic [7:0] cr;
    logic       valid;
  } vepsp_pixel_s;

  typedef struct packed {
    logic [11:0] hs_start;
    logic [11:0] hs_width;
    logic [9:0]  vs_start;
    logic [9:0]  vs_width;
    logic [11:0] line_len;
    logic [9:0]  field_lines;
  } vepsp_timing_s;

  typedef struct packed {
    logic       field;
    logic       vblank;
    logic       hblank;
    logic       valid;
  } vepsp_trc_s;

endpackage

// ==== vepsp_port.sv ====
// Pixel input, sync master/slave and control pin logic of the video encoder
//
// What the document requires of this block and of its video source
// RQ1: Pixel bus uses lines 7..0 in 8-bit mode, 15..0 in 16-bit mode.
// RQ2: Source supplies the stable pixel clock at the documented rates.
// RQ3: Line sync pin driven when master, sampled when slave.
// RQ4: Field/vertical pin carries field in mode 1, vsync in mode 2.
// RQ5: Pixel words ignored while the blanking input is low.
// RQ6: Two configuration bits pick subcarrier reset or real-time control role.
// RQ7: Falling edge in subcarrier reset role restarts subcarrier sequence at field 0.
// RQ8: Address select input sets low bit of control port address.
// RQ9: Reset clears timing generator and loads documented default configuration.
// RQ10: Output frame timing aligns to embedded timing reference codes.
// RQ11: Master mode sync pulse width and position are configurable.
// RQ12: Source may send teletext data only during vertical blanking.
// RQ13: Teletext request stays low unless teletext insertion is selected.
// RQ14: Control port answers at two slave addresses.
// RQ15: 8-bit order is Cb, Y, Cr, Y, captured on rising edges.
// RQ16: 16-bit mode luma low byte, chroma high byte, every second edge.
// RQ17: Slave sync and blanking inputs sampled with the pixel data.
// RQ18: After reset, code decoding restarts before aligned frames are made.
`timescale 1ns/1ps
module vepsp_port #(
  parameter int PIXEL_W = 16
) (
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic [PIXEL_W-1:0]     pixel_bus_in,
  input  wire logic                   blank_n_in,
  input  wire logic                   hsync_n_in,
  input  wire logic                   field_vsync_in,
  input  wire logic                   subcarrier_reset_or_realtime_pin_in,
  input  wire logic                   teletext_data_input_in,
  input  wire logic                   bus_address_low_bit_in,
  input  wire logic                   cfg_master_in,
  input  wire logic [1:0]             cfg_tmode_in,
  input  wire logic                   cfg_wide_in,
  input  wire logic                   pin_role_select_high_in,
  input  wire logic                   pin_role_select_low_in,
  input  wire logic                   cfg_teletext_en_in,
  input  wire vepsp_pkg::vepsp_timing_s cfg_timing_in,
  output logic                        hsync_n_out,
  output logic                        hsync_oe_out,
  output logic                        field_vsync_out,
  output logic                        field_vsync_oe_out,
  output vepsp_pkg::vepsp_pixel_s     pixel_out,
  output logic                        subcarrier_reset_out,
  output logic                        realtime_sample_out,
  output logic                        realtime_data_out,
  output logic                        teletext_request_output_out,
  output logic                        teletext_bit_out,
  output logic                        teletext_bit_valid_out,
  output logic [6:0]                  ctrl_addr_a_out,
  output logic [6:0]                  ctrl_addr_b_out,
  output logic                        frame_locked_out,
  output logic                        pal_out,
  output logic                        dac_b_on_out,
  output logic                        dac_d_on_out
);

  // -----------------------------------------------------------------
  // Input sampling
  // -----------------------------------------------------------------
  logic [15:0] pix_q;
  logic        blank_n_q;
  logic        hsync_n_q;
  logic        fv_q;
  logic        scr_q;
  logic        load_phase;
  vepsp_pkg::vepsp_phase_e phase;
  vepsp_pkg::vepsp_pinrole_e role;
  vepsp_pkg::vepsp_trc_s trc;
  logic [11:0] hcnt;
  logic [9:0]  vcnt;
  logic        field;
  logic        locked;
  logic [7:0]  cb_hold;
  logic        word_valid;
  logic        hs_gen;
  logic        vs_gen;
  logic        hs_fall;
  logic        hs_prev;
  logic        in_vbi;
  vepsp_pkg::vepsp_phase_e phase_now;

  // Sync and blank inputs taken on the same edge as the pixel data (see RQ17)
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pix_q     <= 16'h0000;
      blank_n_q <= 1'b1;
      hsync_n_q <= 1'b1;
      fv_q      <= 1'b0;
      scr_q     <= 1'b1;
    end else begin
      pix_q     <= 16'(pixel_bus_in); // Lowest line is the LSB (see RQ1)
      blank_n_q <= blank_n_in;
      hsync_n_q <= hsync_n_in;
      fv_q      <= field_vsync_in;
      scr_q     <= subcarrier_reset_or_realtime_pin_in;
    end
  end

  // Wide mode loads only on every second edge (see RQ16)
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      load_phase <= 1'b0;
    end else begin
      load_phase <= ~load_phase;
    end
  end

  // A word counts only when blanking input is high (see RQ5)
  assign word_valid = blank_n_q & (~cfg_wide_in | load_phase);

  // The code is seen one word late, so the word now in hand is already the first Cb
  assign phase_now = trc.valid ? vepsp_pkg::VEPSP_PH_CB : phase;

  // -----------------------------------------------------------------
  // Demultiplexing Cb Y Cr Y
  // -----------------------------------------------------------------
  // Phase counter realigned by every decoded reference code (see RQ15)
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase     <= vepsp_pkg::VEPSP_PH_CB;
      cb_hold   <= 8'h80;
      pixel_out <= '0;
    end else begin
      pixel_out.valid <= 1'b0;
      if (word_valid) begin
        if (cfg_wide_in) begin
          // Luma low byte, chroma high byte alternating Cb/Cr (see RQ16)
          pixel_out.y     <= pix_q[7:0];
          if (phase_now == vepsp_pkg::VEPSP_PH_CB) begin
            pixel_out.cb <= pix_q[15:8];
            phase        <= vepsp_pkg::VEPSP_PH_CR;
          end else begin
            pixel_out.cr <= pix_q[15:8];
            phase        <= vepsp_pkg::VEPSP_PH_CB;
          end
          pixel_out.valid <= 1'b1;
        end else begin
          case (phase_now)
            vepsp_pkg::VEPSP_PH_CB: begin
              cb_hold <= pix_q[7:0]; // see RQ15
              phase   <= vepsp_pkg::VEPSP_PH_Y0;
            end
            vepsp_pkg::VEPSP_PH_Y0: begin
              pixel_out.cb    <= cb_hold;
              pixel_out.y     <= pix_q[7:0];
              pixel_out.valid <= 1'b1;
              phase           <= vepsp_pkg::VEPSP_PH_CR;
            end
            vepsp_pkg::VEPSP_PH_CR: begin
              pixel_out.cr <= pix_q[7:0];
              phase        <= vepsp_pkg::VEPSP_PH_Y1;
            end
            vepsp_pkg::VEPSP_PH_Y1: begin
              pixel_out.y     <= pix_q[7:0];
              pixel_out.valid <= 1'b1;
              phase           <= vepsp_pkg::VEPSP_PH_CB;
            end
            default: phase <= vepsp_pkg::VEPSP_PH_CB;
          endcase
        end
      end else if (trc.valid) begin
        phase <= vepsp_pkg::VEPSP_PH_CB;
      end
    end
  end

  // Reference codes appear on the luma/multiplexed byte lane
  vepsp_trc_decoder u_trc (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .word_valid_in (blank_n_q),
    .word_in       (pix_q[7:0]),
    .trc_out       (trc)
  );

  // -----------------------------------------------------------------
  // Timing generator
  // -----------------------------------------------------------------
  // Counters snap to the embedded codes; lock only after first code (see RQ10)
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hcnt   <= 12'h000; // see RQ9
      vcnt   <= 10'h000;
      field  <= 1'b0;
      locked <= 1'b0;    // see RQ18
    end else if (trc.valid && !trc.hblank) begin
      hcnt   <= 12'h000; // see RQ10
      field  <= trc.field;
      locked <= 1'b1;
    end else begin
      if (hcnt >= cfg_timing_in.line_len - 12'h001) begin
        hcnt <= 12'h000;
        if (vcnt >= cfg_timing_in.field_lines - 10'h001) begin
          vcnt  <= 10'h000;
          field <= ~field;
        end else begin
          vcnt <= vcnt + 10'h001;
        end
      end else begin
        hcnt <= hcnt + 12'h001;
      end
      if (trc.valid && trc.vblank && !in_vbi) begin
        vcnt <= 10'h000; // Vertical alignment at start of blanking
      end
    end
  end

  // Pulse position and width from configuration (see RQ11)
  assign hs_gen = (hcnt >= cfg_timing_in.hs_start) &&
                  (hcnt < cfg_timing_in.hs_start + cfg_timing_in.hs_width);
  assign vs_gen = (vcnt >= cfg_timing_in.vs_start) &&
                  (vcnt < cfg_timing_in.vs_start + cfg_timing_in.vs_width);

  // Track vertical blanking from codes only; holds its value between codes
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      in_vbi <= 1'b1;
    end else if (trc.valid) begin
      in_vbi <= trc.vblank;
    end
  end

  // -----------------------------------------------------------------
  // Sync pins: drive when master; in slave only line sync is received, the field/vsync input is masked off
  // -----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hsync_n_out        <= 1'b1;
      hsync_oe_out       <= vepsp_pkg::RST_MASTER;
      field_vsync_out    <= 1'b0;
      field_vsync_oe_out <= vepsp_pkg::RST_MASTER;
    end else begin
      hsync_oe_out    <= cfg_master_in;                // see RQ3
      hsync_n_out     <= ~(hs_gen & locked);
      field_vsync_oe_out <= cfg_master_in;             // see RQ4
      if (cfg_tmode_in == vepsp_pkg::VEPSP_TMODE1) begin
        field_vsync_out <= field;                      // see RQ4
      end else if (cfg_tmode_in == vepsp_pkg::VEPSP_TMODE2) begin
        field_vsync_out <= ~(vs_gen & locked);         // see RQ4
      end else begin
        field_vsync_out <= 1'b0;
      end
    end
  end

  // Slave mode: received line sync edge reported as frame lock evidence
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hs_prev <= 1'b1;
      hs_fall <= 1'b0;
    end else begin
      hs_prev <= hsync_n_q;                            // see RQ3
      hs_fall <= ~cfg_master_in & hs_prev & ~hsync_n_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      frame_locked_out <= 1'b0;
    end else begin
      frame_locked_out <= locked | hs_fall | (frame_locked_out & ~cfg_master_in & fv_q & 1'b0);
    end
  end

  // -----------------------------------------------------------------
  // Subcarrier reset / real-time control pin
  // -----------------------------------------------------------------
  assign role = vepsp_pkg::vepsp_pinrole_e'({pin_role_select_high_in, pin_role_select_low_in}); // see RQ6

  logic scr_prev;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scr_prev             <= 1'b1;
      subcarrier_reset_out <= 1'b0;
      realtime_sample_out  <= 1'b0;
      realtime_data_out    <= 1'b0;
    end else begin
      scr_prev             <= scr_q;
      // High-to-low edge restarts the subcarrier at field 0 (see RQ7)
      subcarrier_reset_out <= (role == vepsp_pkg::VEPSP_PIN_SCR) & scr_prev & ~scr_q;
      realtime_sample_out  <= (role == vepsp_pkg::VEPSP_PIN_RTC);  // see RQ6
      realtime_data_out    <= (role == vepsp_pkg::VEPSP_PIN_RTC) & scr_q;
    end
  end

  // -----------------------------------------------------------------
  // Teletext request and capture
  // -----------------------------------------------------------------
  // Request low unless insertion selected; bit taken every cycle, flagged valid only after a VBI request (see RQ12)
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      teletext_request_output_out <= 1'b0;
      teletext_bit_out            <= 1'b0;
      teletext_bit_valid_out      <= 1'b0;
    end else begin
      teletext_request_output_out <= cfg_teletext_en_in & in_vbi & locked; // see RQ13
      teletext_bit_out            <= teletext_data_input_in;
      teletext_bit_valid_out      <= teletext_request_output_out;
    end
  end

  // -----------------------------------------------------------------
  // Control port addresses and reset defaults
  // -----------------------------------------------------------------
  // Two addresses, low bit from address select input (see RQ8)
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_addr_a_out <= vepsp_pkg::CTRL_ADDR_BASE;
      ctrl_addr_b_out <= vepsp_pkg::CTRL_ADDR_BASE;
      pal_out         <= vepsp_pkg::RST_PAL;       // see RQ9
      dac_b_on_out    <= vepsp_pkg::RST_DAC_B_ON;  // see RQ9
      dac_d_on_out    <= vepsp_pkg::RST_DAC_D_ON;  // see RQ9
    end else begin
      // Bit 1 low for address a and high for b, so the two differ outside reset
      ctrl_addr_a_out <= {vepsp_pkg::CTRL_ADDR_BASE[6:2], 1'b0, bus_address_low_bit_in}; // see RQ8
      ctrl_addr_b_out <= {vepsp_pkg::CTRL_ADDR_BASE[6:2], 1'b1, bus_address_low_bit_in}; // see RQ14
    end
  end

endmodule

// ==== vepsp_port_chk.sv ====
// Checker: port-level assertions for the pixel/sync port
`timescale 1ns/1ps
module vepsp_port_chk (
  input wire logic                  clk_in,
  input wire logic                  rst_in,
  input wire logic                  blank_n_in,
  input wire logic                  subcarrier_reset_or_realtime_pin_in,
  input wire logic                  bus_address_low_bit_in,
  input wire logic                  cfg_master_in,
  input wire logic                  cfg_wide_in,
  input wire logic                  pin_role_select_high_in,
  input wire logic                  pin_role_select_low_in,
  input wire logic                  cfg_teletext_en_in,
  input wire logic                  hsync_oe_out,
  input wire logic                  field_vsync_oe_out,
  input wire vepsp_pkg::vepsp_pixel_s pixel_out,
  input wire logic                  subcarrier_reset_out,
  input wire logic                  teletext_request_output_out,
  input wire logic [6:0]            ctrl_addr_a_out,
  input wire logic [6:0]            ctrl_addr_b_out,
  input wire logic                  frame_locked_out,
  input wire logic                  pal_out,
  input wire logic                  dac_b_on_out,
  input wire logic                  dac_d_on_out
);
  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [1:0] role;
  // Role code of the shared pin
  assign role = {pin_role_select_high_in, pin_role_select_low_in};
  sequence s_fall; role == 2'b01 && $fell(subcarrier_reset_or_realtime_pin_in); endsequence
  sequence s_pulse; ##[1:3] subcarrier_reset_out; endsequence
  property p_scr; s_fall |-> s_pulse; endproperty
  property p_scr_off; (role != 2'b01)[*3] |-> !subcarrier_reset_out; endproperty
  // Three cycles of margin so the reset cycle never feeds the antecedent
  property p_oe_on; cfg_master_in[*3] |-> hsync_oe_out && field_vsync_oe_out; endproperty
  property p_oe_off; !cfg_master_in[*3] |-> !hsync_oe_out && !field_vsync_oe_out; endproperty
  property p_blank; !blank_n_in[*4] |-> !pixel_out.valid; endproperty
  property p_cause; !cfg_wide_in && pixel_out.valid |-> $past(blank_n_in, 2); endproperty
  property p_pulse; !cfg_wide_in && pixel_out.valid |=> !pixel_out.valid; endproperty
  property p_ttx; !cfg_teletext_en_in[*3] |-> !teletext_request_output_out; endproperty
  property p_addr;
    $stable(bus_address_low_bit_in)[*3] |->
      ctrl_addr_a_out[0] == bus_address_low_bit_in && ctrl_addr_a_out != ctrl_addr_b_out;
  endproperty
  property p_dflt;
    $fell(rst_in) |-> dac_b_on_out && !dac_d_on_out && !pal_out && !frame_locked_out;
  endproperty
  a_scr: assert property (p_scr) else $error("no subcarrier reset pulse");
  a_scr_off: assert property (p_scr_off) else $error("stray subcarrier reset");
  a_oe_on: assert property (p_oe_on) else $error("sync pins not driven in master");
  a_oe_off: assert property (p_oe_off) else $error("sync pins driven in slave");
  a_blank: assert property (p_blank) else $error("pixel taken while blanked");
  a_cause: assert property (p_cause) else $error("pixel without unblanked luma");
  a_pulse: assert property (p_pulse) else $error("pixel valid too long");
  a_ttx: assert property (p_ttx) else $error("teletext request while off");
  a_addr: assert property (p_addr) else $error("control address wrong");
  a_dflt: assert property (p_dflt) else $error("reset defaults wrong");
endmodule

bind vepsp_port vepsp_port_chk u_vepsp_port_chk (.clk_in, .rst_in, .blank_n_in,
  .subcarrier_reset_or_realtime_pin_in, .bus_address_low_bit_in, .cfg_master_in, .cfg_wide_in,
  .pin_role_select_high_in, .pin_role_select_low_in, .cfg_teletext_en_in, .hsync_oe_out,
  .field_vsync_oe_out, .pixel_out, .subcarrier_reset_out, .teletext_request_output_out,
  .ctrl_addr_a_out, .ctrl_addr_b_out, .frame_locked_out, .pal_out, .dac_b_on_out, .dac_d_on_out);

// ==== vepsp_src.sv ====
// Partner: behavioural video source driving the pixel bus and blanking
`timescale 1ns/1ps
module vepsp_src (
  input  wire logic        clk_in,
  output logic [15:0]      pix_out,
  output logic             blank_n_out
);
  bit busy = 1'b0;
  initial begin
    pix_out = 16'h0000;
    blank_n_out = 1'b0;
  end
  // Released bus toggles each cycle so stale words never pass as data
  always @(posedge clk_in) if (!busy) begin
    #1;
    pix_out = ~pix_out;
    blank_n_out = 1'b0;
  end
  // One word held for n edges; gap lowers blanking so it is ignored
  task automatic put(input logic [15:0] w, input int n, input bit gap);
    busy = 1'b1;
    @(posedge clk_in);
    #1;
    pix_out = w;
    blank_n_out = !gap;
    repeat (n - 1) begin
      @(posedge clk_in);
      #1;
    end
  endtask
  task automatic release_bus();
    busy = 1'b0;
  endtask
endmodule

// ==== vepsp_trc_decoder.sv ====
// Decoder for timing reference codes embedded in the pixel stream
`timescale 1ns/1ps
module vepsp_trc_decoder (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              word_valid_in,
  input  wire logic [7:0]        word_in,
  output vepsp_pkg::vepsp_trc_s  trc_out
);

  logic [1:0] match;

  // -----------------------------------------------------------------
  // Preamble search FF 00 00 then status word
  // -----------------------------------------------------------------
  // Cleared by reset so decoding always starts afresh (see RQ18)
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      match   <= 2'h0;
      trc_out <= '0;
    end else begin
      trc_out.valid <= 1'b0;
      if (word_valid_in) begin
        case (match)
          2'h0: match <= (word_in == vepsp_pkg::TRC_FF) ? 2'h1 : 2'h0;
          2'h1: match <= (word_in == vepsp_pkg::TRC_00) ? 2'h2 : 2'h0;
          2'h2: match <= (word_in == vepsp_pkg::TRC_00) ? 2'h3 : 2'h0;
          2'h3: begin
            match         <= 2'h0;
            trc_out.field  <= word_in[6];
            trc_out.vblank <= word_in[5];
            trc_out.hblank <= word_in[4];
            trc_out.valid  <= word_in[7]; // Bit 7 is always set in a legal code
          end
          default: match <= 2'h0;
        endcase
      end
    end
  end

endmodule
